// *** hw/dpr_nv_timer.sv ***
// dpr_nv_timer: self-timed storage write cycle
// assumes: start is a one-cycle pulse; a start while busy is ignored
`timescale 1ns/1ps
module dpr_nv_timer #(
    parameter int CYCLES = 800000
) (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic start_in,
    output logic busy_out
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] cnt_q;

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            cnt_q <= '0;
            busy_out <= 1'b0;
        end else if (start_in && !busy_out) begin
            cnt_q <= W'(CYCLES);
            busy_out <= 1'b1;
        end else if (busy_out) begin
            cnt_q <= cnt_q - W'(1);
            busy_out <= (cnt_q != W'(1));
        end
    end
endmodule

// *** hw/dpr_pkg.sv ***
// dpr_pkg: types and pointer helpers of the potentiometer register block
// assumes: dpr_regs.svh is on the include path
package dpr_pkg;
`include "dpr_regs.svh"
    typedef logic [6:0] dpr_wiper_t;
    typedef logic [3:0] dpr_ptr_t;
    typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_MACK} dpr_state_t;
    typedef enum logic [1:0] {K_ID, K_ADDR, K_DATA} dpr_kind_t;

    function automatic dpr_ptr_t dpr_ptr_next(input dpr_ptr_t p);
        dpr_ptr_next = (p >= `DPR_ADDR_ACR) ? `DPR_ADDR_WIPER0 : p + 4'h1;
    endfunction

    function automatic logic dpr_is_gp(input dpr_ptr_t p);
        dpr_is_gp = (p >= `DPR_ADDR_GP_FIRST) && (p <= `DPR_ADDR_GP_LAST);
    endfunction
endpackage

// *** hw/dpr_regs.svh ***
// dpr_regs.svh: register offsets, field positions, reset values and timing counts
// assumes: included by dpr_pkg, dpr_top and dpr_top_tb under a guard; clock is 40 MHz
`ifndef DPR_REGS_SVH
`define DPR_REGS_SVH
`define DPR_ADDR_WIPER0 4'h0
`define DPR_ADDR_WIPER1 4'h1
`define DPR_ADDR_GP_FIRST 4'h2
`define DPR_ADDR_GP_LAST 4'h6
`define DPR_ADDR_RSVD 4'h7
`define DPR_ADDR_ACR 4'h8
`define DPR_ACR_VOL_BIT 7
`define DPR_ACR_SHUTDOWN_N_BIT 6
`define DPR_ACR_BUSY_BIT 5
`define DPR_WIPER_RST 7'h40
`define DPR_INIT_FACTORY 7'h20
`define DPR_GP_FACTORY 8'h00
`define DPR_VOL_RST 1'b0
`define DPR_SHUTDOWN_N_RST 1'b1
// arbitrary device-type prefix
`define DPR_ID_PREFIX 4'h6
`define DPR_CLK_NS 25
`define DPR_CLK_KHZ 40000
`define DPR_RECALL_NS 1000
`define DPR_NV_WRITE_MS 20
`define DPR_RECALL_CYCLES ((`DPR_RECALL_NS + `DPR_CLK_NS - 1) / `DPR_CLK_NS)
`define DPR_NV_WRITE_CYCLES (`DPR_NV_WRITE_MS * `DPR_CLK_KHZ)
`endif

// *** hw/dpr_sync.sv ***
// dpr_sync: two-flop synchroniser for pin levels
// assumes: inputs are slow levels from outside the clock domain
`timescale 1ns/1ps
module dpr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic [W-1:0] pins_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            meta_q <= RST;
            sync_out <= RST;
        end else begin
            meta_q <= pins_in;
            sync_out <= meta_q;
        end
    end
endmodule

// *** hw/dpr_top.sv ***
// dpr_top: serial slave, register bank and shutdown control of a dual potentiometer
// assumes: srst_in is the power-up reset; bus pins are pulled up outside
`timescale 1ns/1ps
`include "dpr_regs.svh"
module dpr_top #(
    parameter int NV_WRITE_CYCLES = `DPR_NV_WRITE_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic shutdown_n_in,
    input wire logic [2:0] slave_addr_pins_in,
    output dpr_pkg::dpr_wiper_t wiper0_out,
    output dpr_pkg::dpr_wiper_t wiper1_out,
    output logic high_terminal_open_out,
    output logic wiper_to_low_out
);
    import dpr_pkg::*;

    localparam logic [5:0] RECALL_CYC = 6'(`DPR_RECALL_CYCLES);

    // ----------------------------------------------------------------
    // pin synchronisers and bus events
    // ----------------------------------------------------------------
    logic scl_s, sda_s, shutdown_n_pin_s;
    logic [2:0] addr_s;
    logic scl_p_q, sda_p_q;
    logic scl_rise, scl_fall, start_det, stop_det;

    dpr_sync #(.W(6), .RST(6'b111000)) u_sync (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .pins_in({scl_in, sda_in, shutdown_n_in, slave_addr_pins_in}),
        .sync_out({scl_s, sda_s, shutdown_n_pin_s, addr_s})
    );

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_p_q;
    assign scl_fall = !scl_s && scl_p_q;
    assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    dpr_state_t state_q;
    dpr_kind_t kind_q;
    logic [2:0] bitcnt_q;
    logic [7:0] shift_q, tx_q, rd_word;
    logic full_q, ack_ok_q, rw_q;
    dpr_ptr_t ptr_q;
    dpr_wiper_t wiper0_q, wiper1_q, init0_q, init1_q;
    logic [7:0] gp_q [0:4];
    logic vol_q, shutdown_n_q, nv_pend_q, nv_busy;
    logic [5:0] recall_cnt_q;
    logic recall_done_q, recall_fire;
    logic [7:0] byte_in;
    logic byte_done, wr_fire, id_match, nv_wr, ctl_ok, shut_req;

    assign byte_in = {shift_q[6:0], sda_s};
    assign byte_done = scl_rise && (state_q == ST_RECV) && (bitcnt_q == 3'd7);
    assign wr_fire = byte_done && (kind_q == K_DATA) && !start_det && !stop_det;
    assign id_match = (byte_in[7:1] == {`DPR_ID_PREFIX, addr_s});
    assign ctl_ok = !nv_busy;
    assign nv_wr = wr_fire && ((dpr_is_gp(ptr_q)) ||
                   (ctl_ok && !vol_q && (ptr_q <= `DPR_ADDR_WIPER1)));
    assign recall_fire = !recall_done_q && (recall_cnt_q == RECALL_CYC);
    assign shut_req = !shutdown_n_q || !shutdown_n_pin_s;

    // ----------------------------------------------------------------
    // power-up recall: wipers stay mid-scale, then load initial values
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            recall_cnt_q <= '0;
            recall_done_q <= 1'b0;
        end else if (!recall_done_q) begin
            recall_cnt_q <= recall_cnt_q + 6'd1;
            recall_done_q <= recall_fire;
        end
    end

    // ----------------------------------------------------------------
    // serial slave; held idle until recall ends so a start is ignored
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (srst_in || !recall_done_q) begin
            state_q <= ST_IDLE;
            kind_q <= K_ID;
            bitcnt_q <= '0;
            shift_q <= '0;
            tx_q <= '0;
            full_q <= 1'b0;
            ack_ok_q <= 1'b0;
            rw_q <= 1'b0;
            ptr_q <= `DPR_ADDR_WIPER0;
            sda_oe_out <= 1'b0;
        end else if (start_det) begin
            state_q <= ST_RECV;
            kind_q <= K_ID;
            bitcnt_q <= '0;
            full_q <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (stop_det) begin
            state_q <= ST_IDLE;
            full_q <= 1'b0;
            sda_oe_out <= 1'b0;
        end else begin
            case (state_q)
                ST_RECV: begin
                    if (scl_rise) begin
                        shift_q <= byte_in;
                        bitcnt_q <= bitcnt_q + 3'd1;
                        if (bitcnt_q == 3'd7) begin
                            full_q <= 1'b1;
                            case (kind_q)
                                K_ID: begin
                                    ack_ok_q <= id_match;
                                    rw_q <= byte_in[0];
                                end
                                K_ADDR: begin
                                    ack_ok_q <= 1'b1;
                                    ptr_q <= byte_in[3:0];
                                end
                                default: begin
                                    ack_ok_q <= 1'b1;
                                    ptr_q <= dpr_ptr_next(ptr_q);
                                end
                            endcase
                        end
                    end else if (scl_fall && full_q) begin
                        full_q <= 1'b0;
                        sda_oe_out <= ack_ok_q;
                        state_q <= ack_ok_q ? ST_ACK : ST_IDLE;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bitcnt_q <= '0;
                        if (kind_q == K_ID && rw_q) begin
                            kind_q <= K_DATA;
                            tx_q <= rd_word;
                            sda_oe_out <= !rd_word[7];
                            state_q <= ST_SEND;
                        end else begin
                            kind_q <= (kind_q == K_ID) ? K_ADDR : K_DATA;
                            sda_oe_out <= 1'b0;
                            state_q <= ST_RECV;
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_fall) begin
                        if (bitcnt_q == 3'd7) begin
                            bitcnt_q <= '0;
                            sda_oe_out <= 1'b0;
                            state_q <= ST_MACK;
                        end else begin
                            bitcnt_q <= bitcnt_q + 3'd1;
                            tx_q <= {tx_q[6:0], 1'b0};
                            sda_oe_out <= !tx_q[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            state_q <= ST_IDLE;
                        end else begin
                            ptr_q <= dpr_ptr_next(ptr_q);
                            full_q <= 1'b1;
                        end
                    end else if (scl_fall && full_q) begin
                        full_q <= 1'b0;
                        tx_q <= rd_word;
                        sda_oe_out <= !rd_word[7];
                        state_q <= ST_SEND;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // open drain: the data line is only ever pulled low
    always_ff @(posedge clk_sys_in) begin
        sda_out <= 1'b0;
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb begin
        if (ptr_q == `DPR_ADDR_WIPER0) begin
            rd_word = {1'b0, vol_q ? wiper0_q : init0_q};
        end else if (ptr_q == `DPR_ADDR_WIPER1) begin
            rd_word = {1'b0, vol_q ? wiper1_q : init1_q};
        end else if (dpr_is_gp(ptr_q)) begin
            rd_word = gp_q[3'(ptr_q - `DPR_ADDR_GP_FIRST)];
        end else if (ptr_q == `DPR_ADDR_ACR) begin
            rd_word = {vol_q, shutdown_n_q, nv_busy, 5'b0_0000};
        end else begin
            rd_word = 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // register bank; shutdown gates none of it
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            wiper0_q <= `DPR_WIPER_RST;
            wiper1_q <= `DPR_WIPER_RST;
        end else if (recall_fire) begin
            wiper0_q <= init0_q;
            wiper1_q <= init1_q;
        end else if (wr_fire && ctl_ok) begin
            if (ptr_q == `DPR_ADDR_WIPER0) begin
                wiper0_q <= byte_in[6:0];
            end else if (ptr_q == `DPR_ADDR_WIPER1) begin
                wiper1_q <= byte_in[6:0];
            end
        end
    end

    // stored values come back at power-up reset as the factory contents
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            init0_q <= `DPR_INIT_FACTORY;
            init1_q <= `DPR_INIT_FACTORY;
            for (int i = 0; i < 5; i++) begin
                gp_q[i] <= `DPR_GP_FACTORY;
            end
        end else if (wr_fire) begin
            if (ctl_ok && !vol_q && ptr_q == `DPR_ADDR_WIPER0) begin
                init0_q <= byte_in[6:0];
            end else if (ctl_ok && !vol_q && ptr_q == `DPR_ADDR_WIPER1) begin
                init1_q <= byte_in[6:0];
            end else if (dpr_is_gp(ptr_q)) begin
                gp_q[3'(ptr_q - `DPR_ADDR_GP_FIRST)] <= byte_in;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            vol_q <= `DPR_VOL_RST;
            shutdown_n_q <= `DPR_SHUTDOWN_N_RST;
        end else if (wr_fire && ctl_ok && ptr_q == `DPR_ADDR_ACR) begin
            vol_q <= byte_in[`DPR_ACR_VOL_BIT];
            shutdown_n_q <= byte_in[`DPR_ACR_SHUTDOWN_N_BIT];
        end
    end

    // ----------------------------------------------------------------
    // storage write cycle, launched by the stop that ends the write
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            nv_pend_q <= 1'b0;
        end else if (nv_wr) begin
            nv_pend_q <= 1'b1;
        end else if (stop_det || start_det) begin
            nv_pend_q <= 1'b0;
        end
    end

    dpr_nv_timer #(.CYCLES(NV_WRITE_CYCLES)) u_nv_timer (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .start_in(stop_det && nv_pend_q),
        .busy_out(nv_busy)
    );

    // ----------------------------------------------------------------
    // analog-facing outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            high_terminal_open_out <= 1'b0;
            wiper_to_low_out <= 1'b0;
            wiper0_out <= `DPR_WIPER_RST;
            wiper1_out <= `DPR_WIPER_RST;
        end else begin
            high_terminal_open_out <= shut_req;
            wiper_to_low_out <= shut_req;
            wiper0_out <= wiper0_q;
            wiper1_out <= wiper1_q;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    property p_wiper_mid;
        disable iff (1'b0) srst_in |=> (wiper0_q == `DPR_WIPER_RST) && (wiper1_q == `DPR_WIPER_RST);
    endproperty
    a_wiper_mid: assert property (p_wiper_mid) else $error("wiper not mid-scale after reset");

    property p_recall;
        $rose(recall_done_q) |-> (wiper0_q == init0_q) && (wiper1_q == init1_q);
    endproperty
    a_recall: assert property (p_recall) else $error("wipers not loaded at recall");

    property p_init_copies;
        wr_fire && ctl_ok && !vol_q && ptr_q == `DPR_ADDR_WIPER0 |=> wiper0_q == init0_q;
    endproperty
    a_init_copies: assert property (p_init_copies) else $error("initial write not copied to wiper");

    property p_vol_only;
        wr_fire && vol_q && ptr_q == `DPR_ADDR_WIPER1 |=> $stable(init1_q);
    endproperty
    a_vol_only: assert property (p_vol_only) else $error("volatile write reached initial value");

    property p_shut;
        shut_req |=> high_terminal_open_out && wiper_to_low_out;
    endproperty
    a_shut: assert property (p_shut) else $error("shutdown request not applied");

    property p_shut_hold;
        high_terminal_open_out && !wr_fire && recall_done_q |=> $stable(wiper0_q) && $stable(wiper1_q);
    endproperty
    a_shut_hold: assert property (p_shut_hold) else $error("wiper changed in shutdown");

    property p_busy_reject;
        wr_fire && nv_busy && (ptr_q <= `DPR_ADDR_WIPER1 || ptr_q == `DPR_ADDR_ACR) |=>
            $stable(wiper0_q) && $stable(wiper1_q) && $stable(vol_q) && $stable(shutdown_n_q);
    endproperty
    a_busy_reject: assert property (p_busy_reject) else $error("write accepted while busy");

    property p_acr_read;
        ptr_q == `DPR_ADDR_ACR |-> rd_word[4:0] == 5'b0_0000 && rd_word[`DPR_ACR_BUSY_BIT] == nv_busy;
    endproperty
    a_acr_read: assert property (p_acr_read) else $error("control register read wrong");

    property p_wrap;
        state_q == ST_MACK && scl_rise && !sda_s && !start_det && !stop_det && ptr_q == `DPR_ADDR_ACR
            |=> ptr_q == `DPR_ADDR_WIPER0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

    property p_nv_start;
        stop_det && nv_pend_q && !nv_busy |=> nv_busy [*8];
    endproperty
    a_nv_start: assert property (p_nv_start) else $error("storage write not started at stop");

    property p_no_ack;
        state_q == ST_RECV && full_q && scl_fall && !ack_ok_q && !start_det && !stop_det
            |=> !sda_oe_out && state_q == ST_IDLE;
    endproperty
    a_no_ack: assert property (p_no_ack) else $error("acknowledged a foreign address");

    property p_sda_edge;
        $rose(sda_oe_out) |-> $past(scl_fall);
    endproperty
    a_sda_edge: assert property (p_sda_edge) else $error("data driven away from clock fall");

    c_write: cover property (wr_fire && ctl_ok && ptr_q == `DPR_ADDR_WIPER0);
    c_read: cover property (state_q == ST_SEND ##[1:400] state_q == ST_MACK);
    c_nv_cycle: cover property (stop_det && nv_pend_q);
    c_shutdown: cover property ($rose(high_terminal_open_out));
endmodule

// *** tb/dpr_mst.sv ***
// dpr_mst: serial bus master model; drives scl and pulls sda low
// assumes: the bench resolves sda with a pull-up and feeds it back
`timescale 1ns/1ps
module dpr_mst (
    input wire logic clk_sys_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic tk(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    // --------------------------------
    // bus conditions
    // --------------------------------
    // sda is set while scl is low and moves again while scl is high, so the slave sees start or stop
    task automatic cond(input logic d0, input logic d1);
        tk(2);
        sda_low_out = d0;
        tk(2);
        scl_out = 1'b1;
        tk(4);
        sda_low_out = d1;
        tk(4);
    endtask
    task automatic start();
        cond(1'b0, 1'b1);
        scl_out = 1'b0;
    endtask
    task automatic stop();
        cond(1'b1, 1'b0);
    endtask
    // data set mid low phase, read late in high phase: the slave's
    // synchroniser delay would make an early sample see stale data
    task automatic bit_io(input logic b, output logic r);
        tk(2);
        sda_low_out = !b;
        tk(2);
        scl_out = 1'b1;
        tk(3);
        r = sda_in;
        tk(1);
        scl_out = 1'b0;
    endtask
    // one byte msb first plus the ninth bit; ab 0 pulls the ninth bit low
    task automatic xb(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ab, a);
    endtask
endmodule

// *** tb/dpr_top_tb.sv ***
// dpr_top_tb: register tests of the potentiometer block over its serial port
// assumes: dpr_mst is the only bus master; the data line is pulled up here, scl is driven directly
`timescale 1ns/1ps
`include "dpr_regs.svh"
module dpr_top_tb;
    import dpr_pkg::*;
    logic clk_sys_in, srst_in, shutdown_n_n, scl, m_low, sda_out, sda_oe_out, hto, wtl;
    logic [2:0] pins;
    dpr_wiper_t w0, w1;
    int failures, checks_done, cyc;
    wire logic sda = !(m_low || (sda_oe_out && !sda_out));
    dpr_top #(.NV_WRITE_CYCLES(2000)) u_dpr_top (
        .clk_sys_in(clk_sys_in), .srst_in(srst_in), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_out(sda_oe_out), .shutdown_n_in(shutdown_n_n),
        .slave_addr_pins_in(pins), .wiper0_out(w0), .wiper1_out(w1),
        .high_terminal_open_out(hto), .wiper_to_low_out(wtl));
    dpr_mst u_dpr_mst (.clk_sys_in(clk_sys_in), .sda_in(sda), .scl_out(scl), .sda_low_out(m_low));
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    // --------------------------------
    // checks and transfers
    // --------------------------------
    task automatic summarize();
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic send(input logic [7:0] d, input logic ea);
        logic [7:0] q;
        logic a;
        u_dpr_mst.xb(d, 1'b1, q, a);
        chk({7'h0, !a}, {7'h0, ea});
    endtask
    task automatic head(input logic [3:0] a);
        u_dpr_mst.start();
        send({`DPR_ID_PREFIX, pins, 1'b0}, 1'b1);
        send({4'h0, a}, 1'b1);
    endtask
    // one storage register per transaction, as the bus master must
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        head(a);
        send(d, 1'b1);
        u_dpr_mst.stop();
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e[$]);
        logic [7:0] q;
        logic k;
        head(a);
        u_dpr_mst.start();
        send({`DPR_ID_PREFIX, pins, 1'b1}, 1'b1);
        foreach (e[i]) begin
            u_dpr_mst.xb(8'hff, i == e.size() - 1, q, k);
            chk(q, e[i]);
        end
        u_dpr_mst.stop();
    endtask
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            summarize();
        end
    end
    // --------------------------------
    // tests
    // --------------------------------
    initial begin
        failures = 0;
        checks_done = 0;
        cyc = 0;
        srst_in = 1'b1;
        shutdown_n_n = 1'b1;
        pins = 3'b101;
        u_dpr_mst.tk(5);
        chk({1'b0, w0}, 8'h40);
        u_dpr_mst.tk(1);
        srst_in = 1'b0;
        u_dpr_mst.tk(60);
        chk({1'b0, w0}, 8'h20);
        chk({1'b0, w1}, 8'h20);
        rd(4'h8, '{8'h40});
        $display("test reset done");
        wr(4'h0, 8'h33);
        chk({1'b0, w0}, 8'h33);
        rd(4'h8, '{8'h60});
        wr(4'h1, 8'h11);
        wr(4'h8, 8'h80);
        u_dpr_mst.tk(2100);
        rd(4'h1, '{8'h20});
        rd(4'h8, '{8'h40});
        $display("test busy done");
        wr(4'h8, 8'hdf);
        rd(4'h8, '{8'hc0});
        wr(4'h0, 8'h7f);
        chk({1'b0, w0}, 8'h7f);
        wr(4'h1, 8'h55);
        chk({1'b0, w1}, 8'h55);
        rd(4'h7, '{8'h00, 8'hc0, 8'h7f, 8'h55});
        wr(4'h8, 8'h40);
        rd(4'h0, '{8'h33, 8'h20});
        $display("test select done");
        wr(4'h8, 8'h00);
        chk({6'h0, hto, wtl}, 8'h03);
        chk({1'b0, w0}, 8'h7f);
        wr(4'h2, 8'h5a);
        u_dpr_mst.tk(2100);
        rd(4'h2, '{8'h5a, 8'h00});
        wr(4'h8, 8'h40);
        chk({6'h0, hto, wtl}, 8'h00);
        chk({1'b0, w0}, 8'h7f);
        shutdown_n_n = 1'b0;
        u_dpr_mst.tk(10);
        chk({6'h0, hto, wtl}, 8'h03);
        shutdown_n_n = 1'b1;
        $display("test shutdown done");
        wr(4'h7, 8'hff);
        pins = 3'b010;
        u_dpr_mst.tk(4);
        rd(4'h7, '{8'h00});
        u_dpr_mst.start();
        send({`DPR_ID_PREFIX, 3'b101, 1'b0}, 1'b0);
        u_dpr_mst.stop();
        $display("test address done");
        summarize();
    end
endmodule
